/* bench/cgtsr_core_assertions.sv */
// Purpose: Port checker for the guest, timer and status slice
// Assumes: Default parameters, EXTERNAL_IRQ_CONTROLLER layout, no cop2 or fpu
// Notes:   Keeps its own copy of the compare value
`timescale 1ns/10ps
`include "cgtsr_regs.vh"
module cgtsr_chk (
    // Clock and reset
    input wire        clk,
    input wire        rst_n,
    // Register access
    input wire        reg_wr,
    input wire        reg_rd,
    input wire [7:0]  reg_sel,
    input wire [31:0] reg_wdata,
    input wire [31:0] reg_rdata_q,
    // Core inputs
    input wire [31:0] count_value,
    input wire [2:0]  timer_irq_route,
    input wire [5:0]  ext_irq,
    input wire        taken_in_root,
    input wire [15:0] guest_bus_vector,
    input wire        debug_mode_flag,
    input wire [3:0]  cop_access,
    // Core outputs
    input wire        timer_irq_out,
    input wire [5:0]  guest_pending_q,
    input wire [15:0] guest_vector_q,
    input wire        irq_enabled_q,
    input wire        cop_unusable_exc_q
);
    // ****************************************
    // Compare shadow and properties
    // ****************************************
    logic [31:0] cmp_q;
    wire         cmp_wr = reg_wr && reg_sel == `CGTSR_SEL_CMP;
    always @(posedge clk or negedge rst_n)
        if (!rst_n) cmp_q <= 32'h0;
        else if (cmp_wr) cmp_q <= reg_wdata;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    AST_TMR_SET: assert property (
        count_value == cmp_q && !cmp_wr |=> timer_irq_out)
        else $error("Timer irq missing on match");
    AST_TMR_HOLD: assert property (
        timer_irq_out && !cmp_wr |=> timer_irq_out)
        else $error("Timer irq dropped without write");
    AST_TMR_CLR: assert property (
        cmp_wr && count_value != cmp_q && count_value != reg_wdata
        |=> !timer_irq_out)
        else $error("Compare write left timer irq set");
    AST_ROUTE: assert property (
        timer_irq_out && $past(timer_irq_out) && timer_irq_route >= 3'h2
        && $stable(timer_irq_route)
        |-> guest_pending_q[timer_irq_route - 3'h2])
        else $error("Timer irq not routed");
    AST_EXT: assert property (
        ext_irq != 6'h0 |=> (guest_pending_q & $past(ext_irq)) == $past(ext_irq))
        else $error("External irq not pending");
    AST_VEC: assert property (
        !taken_in_root |=> guest_vector_q == $past(guest_bus_vector))
        else $error("Guest vector not from guest bus");
    AST_DBG: assert property (
        debug_mode_flag |=> !irq_enabled_q)
        else $error("Irq enabled in debug mode");
    AST_NCC: assert property (
        reg_rd && reg_sel == `CGTSR_SEL_GEXT |=> reg_rdata_q[7:6] == 2'h1)
        else $error("Nested cacheability not 01");
    AST_COP3: assert property (
        cop_access[3] |=> cop_unusable_exc_q)
        else $error("Cop3 access without exception");
endmodule
bind cgtsr_core cgtsr_chk u_cgtsr_chk (.clk, .rst_n, .reg_wr, .reg_rd,
    .reg_sel, .reg_wdata, .reg_rdata_q, .count_value, .timer_irq_route,
    .ext_irq, .taken_in_root, .guest_bus_vector, .debug_mode_flag,
    .cop_access, .timer_irq_out, .guest_pending_q, .guest_vector_q,
    .irq_enabled_q, .cop_unusable_exc_q);

/* bench/cgtsr_core_tb.sv */
// Purpose: Self-checking bench for the guest, timer and status slice
// Assumes: Default parameters, EXTERNAL_IRQ_CONTROLLER layout
// Notes:   Non-EXTERNAL_IRQ_CONTROLLER injection layout is not exercised here
`timescale 1ns/10ps
`include "cgtsr_regs.vh"
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin fails++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e); end end
module cgtsr_core_tb;
    // ****************************************
    // Stimulus and instance
    // ****************************************
    logic        clk = 1'h0, rst_n = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0;
    logic        guest_irq_take = 1'h0, taken_in_root = 1'h0;
    logic        debug_mode_flag = 1'h0, guest_cache_ctl_en = 1'h0;
    logic        guest_cp0_access_en = 1'h0, cache_idx_inv_guest = 1'h0;
    logic        field_change_event = 1'h0;
    logic [7:0]  reg_sel = 8'h0, irq_request = 8'h0;
    logic [31:0] reg_wdata = 32'h0, count_value = 32'h1, d, r;
    logic [2:0]  timer_irq_route = 3'h2, guest_reg_group_acc = 3'h0;
    logic [5:0]  ext_irq = 6'h0;
    logic [9:0]  requested_priority_level = 10'h0;
    logic [3:0]  ext_ctrl_shadow_set = 4'h0, highest_shadow_set = 4'h0;
    logic [3:0]  cop_access = 4'h0, guest_ss_lo_q, guest_ss_hi_q;
    logic [15:0] bus_vector = 16'h0, guest_bus_vector = 16'h0;
    wire  [31:0] reg_rdata_q;
    wire  [15:0] guest_vector_q;
    wire  [7:0]  irq_selected_q;
    wire  [5:0]  guest_pending_q;
    wire         timer_irq_out, irq_enabled_q, user_mode_q;
    wire         guest_privileged_trap, field_change_exc_q;
    wire         cop_unusable_exc_q;
    int          fails = 0, n_checks = 0, i;
    always #12.5 clk = ~clk;
    cgtsr_core u_cgtsr_core (.clk, .rst_n, .reg_wr, .reg_rd, .reg_sel,
        .reg_wdata, .reg_rdata_q, .count_value, .timer_irq_route, .ext_irq,
        .guest_irq_take, .taken_in_root, .requested_priority_level,
        .ext_ctrl_shadow_set, .bus_vector, .guest_bus_vector,
        .debug_mode_flag, .irq_request, .highest_shadow_set,
        .guest_cache_ctl_en, .guest_cp0_access_en, .cache_idx_inv_guest,
        .guest_reg_group_acc, .field_change_event, .cop_access,
        .timer_irq_out, .guest_pending_q, .guest_vector_q, .guest_ss_lo_q,
        .guest_ss_hi_q, .irq_enabled_q, .irq_selected_q, .user_mode_q,
        .guest_privileged_trap, .field_change_exc_q, .cop_unusable_exc_q);
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wr(input [7:0] s, input [31:0] v);
        @(posedge clk);
        reg_wr <= 1'h1;
        reg_sel <= s;
        reg_wdata <= v;
        @(posedge clk);
        reg_wr <= 1'h0;
    endtask
    task automatic rd(input [7:0] s);
        @(posedge clk);
        reg_rd <= 1'h1;
        reg_sel <= s;
        @(posedge clk);
        reg_rd <= 1'h0;
        tick(1);
        d = reg_rdata_q;
    endtask
    task automatic print_verdict;
        $display("checks=%0d fails=%0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // ****************************************
    // Scenarios
    // ****************************************
    initial begin
        void'($urandom(57696));
        tick(8);
        rst_n <= 1'h1;
        rd(`CGTSR_SEL_STAT); `CHK(d, `CGTSR_STAT_RST)
        rd(`CGTSR_SEL_GEXT); `CHK(d, 32'h40)
        wr(`CGTSR_SEL_GEXT, 32'hffffffff);
        rd(`CGTSR_SEL_GEXT); `CHK(d, 32'h5f)
        field_change_event <= 1'h1;
        tick(2); `CHK(field_change_exc_q, 1'h0)
        wr(`CGTSR_SEL_GEXT, 32'h0);
        tick(2); `CHK(field_change_exc_q, 1'h1)
        guest_cp0_access_en <= 1'h1;
        guest_reg_group_acc <= 3'($urandom_range(7, 1));
        tick(3); `CHK(guest_privileged_trap, 1'h0)
        wr(`CGTSR_SEL_GEXT, 32'h7);
        tick(2); `CHK(guest_privileged_trap, 1'h1)
        wr(`CGTSR_SEL_STAT, 32'hffffffff);
        rd(`CGTSR_SEL_STAT); `CHK(d & 32'he00000ff, 32'h17)
        for (i = 0; i < 16; i++) begin
            r = $urandom;
            debug_mode_flag <= r[8];
            cop_access <= {r[11:9], 1'h0};
            ext_irq <= r[21:16];
            irq_request <= r[31:24];
            wr(`CGTSR_SEL_STAT, r);
            tick(2);
            `CHK(irq_enabled_q, r[0] & !r[1] & !r[2] & !r[8])
            if (!r[8]) `CHK(user_mode_q, r[4] & !r[1] & !r[2])
            `CHK(cop_unusable_exc_q, |r[11:9])
        end
        r = $urandom;
        highest_shadow_set <= r[7:4];
        wr(`CGTSR_SEL_SSMAP, r);
        rd(`CGTSR_SEL_SSMAP); `CHK(d, {28'h0, r[3:0]})
        `CHK(guest_ss_hi_q, r[3:0] + r[7:4])
        wr(`CGTSR_SEL_VIRQ, r);
        rd(`CGTSR_SEL_VIRQ); `CHK(d, r & 32'hff3cffff)
        r = $urandom;
        @(posedge clk);
        guest_irq_take <= 1'h1;
        taken_in_root <= 1'h1;
        requested_priority_level <= r[9:0];
        ext_ctrl_shadow_set <= r[13:10];
        bus_vector <= r[31:16];
        @(posedge clk);
        guest_irq_take <= 1'h0;
        rd(`CGTSR_SEL_VIRQ);
        `CHK(d, {r[7:0], 2'h0, r[13:10], 2'h0, r[31:16]})
        `CHK(guest_vector_q, r[31:16])
        taken_in_root <= 1'h0;
        guest_bus_vector <= ~r[31:16];
        tick(2); `CHK(guest_vector_q, ~r[31:16])
        ext_irq <= 6'h0;
        timer_irq_route <= 3'($urandom_range(7, 2));
        count_value <= r + 32'h5;
        wr(`CGTSR_SEL_CMP, r);
        rd(`CGTSR_SEL_CMP); `CHK(d, r)
        `CHK(timer_irq_out, 1'h0)
        @(posedge clk);
        count_value <= r;
        for (i = 0; i < 8 && timer_irq_out !== 1'h1; i++) tick(1);
        if (i == 8) begin
            fails++;
            print_verdict();
        end
        count_value <= r + 32'h1;
        tick(4); `CHK(timer_irq_out, 1'h1)
        `CHK(guest_pending_q[timer_irq_route - 3'h2], 1'h1)
        rd(`CGTSR_SEL_CMP); `CHK(d, r)
        wr(`CGTSR_SEL_CMP, r + 32'h9);
        tick(1); `CHK(timer_irq_out, 1'h0)
        print_verdict();
    end
endmodule

/* design/cgtsr_core.v */
// Purpose: Guest interrupt injection, shadow map, timer compare,
//          guest trap controls and mode/interrupt status registers
// Assumes: Single core clock; count and interrupt bus are same-domain
// Notes:   Registers reached by coprocessor register/select code
`timescale 1ns/10ps
`include "cgtsr_regs.vh"

module cgtsr_core #(
    parameter HAS_MCU_EXT = 1'b0,
    parameter HAS_EIC     = 1'b1,
    parameter HAS_GEXT    = 1'b1,
    parameter HAS_CGI     = 1'b1,
    parameter HAS_OG      = 1'b1,
    parameter HAS_BG      = 1'b1,
    parameter HAS_MG      = 1'b1,
    parameter HAS_LSS     = 1'b1,
    parameter HAS_COP2    = 1'b0,
    parameter HAS_FPU     = 1'b0
) (
    // Clock and reset
    input  wire        clk,
    input  wire        rst_n,
    // Register access
    input  wire        reg_wr,
    input  wire        reg_rd,
    input  wire [7:0]  reg_sel,
    input  wire [31:0] reg_wdata,
    output reg  [31:0] reg_rdata_q,
    // Free-running count and interrupt routing
    input  wire [31:0] count_value,
    input  wire [2:0]  timer_irq_route,
    input  wire [5:0]  ext_irq,
    // Root interrupt bus
    input  wire        guest_irq_take,
    input  wire        taken_in_root,
    input  wire [9:0]  requested_priority_level,
    input  wire [3:0]  ext_ctrl_shadow_set,
    input  wire [15:0] bus_vector,
    input  wire [15:0] guest_bus_vector,
    // Core state
    input  wire        debug_mode_flag,
    input  wire [7:0]  irq_request,
    input  wire [3:0]  highest_shadow_set,
    input  wire        guest_cache_ctl_en,
    input  wire        guest_cp0_access_en,
    input  wire        cache_idx_inv_guest,
    input  wire [2:0]  guest_reg_group_acc,
    input  wire        field_change_event,
    input  wire [3:0]  cop_access,
    // Outputs
    output reg         timer_irq_out,
    output reg  [5:0]  guest_pending_q,
    output reg  [15:0] guest_vector_q,
    output reg  [3:0]  guest_ss_lo_q,
    output reg  [3:0]  guest_ss_hi_q,
    output reg         irq_enabled_q,
    output reg  [7:0]  irq_selected_q,
    output reg         user_mode_q,
    output reg         guest_privileged_trap,
    output reg         field_change_exc_q,
    output reg         cop_unusable_exc_q
);

    // ****************************************
    // Field widths and helpers
    // ****************************************
    localparam PRI_W = HAS_MCU_EXT ? 10 : 8;

    function [31:0] bitset;
        input [4:0] pos;
        begin
            bitset = 32'h0000_0001 << pos;
        end
    endfunction

    wire wr_virq  = reg_wr && (reg_sel == `CGTSR_SEL_VIRQ);
    wire wr_ssmap = reg_wr && (reg_sel == `CGTSR_SEL_SSMAP);
    wire wr_cmp   = reg_wr && (reg_sel == `CGTSR_SEL_CMP);
    wire wr_gext  = reg_wr && (reg_sel == `CGTSR_SEL_GEXT);
    wire wr_stat  = reg_wr && (reg_sel == `CGTSR_SEL_STAT);

    // ****************************************
    // Guest virtual interrupt control
    // ****************************************
    reg [7:0]       vip_q;
    reg [PRI_W-1:0] gpri_q;
    reg [3:0]       gess_q;
    reg [15:0]      guest_vector_offset_q;

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            vip_q  <= 8'h00;
            gpri_q <= {PRI_W{1'b0}};
            gess_q <= 4'h0;
            guest_vector_offset_q <= 16'h0000;
        end else begin
            if (wr_virq) begin
                vip_q  <= reg_wdata[`CGTSR_VIP_HI:`CGTSR_VIP_LO];
                gpri_q <= reg_wdata[`CGTSR_PRI_LO+PRI_W-1:`CGTSR_PRI_LO];
                gess_q <= reg_wdata[`CGTSR_ESS_HI:`CGTSR_ESS_LO];
                guest_vector_offset_q <= reg_wdata[`CGTSR_VEC_HI:0];
            end
            // Hardware capture wins over a same-cycle software write
            if (guest_irq_take && HAS_EIC) begin
                gpri_q <= requested_priority_level[PRI_W-1:0];
                gess_q <= ext_ctrl_shadow_set;
                guest_vector_offset_q <= bus_vector;
            end
        end
    end

    wire [31:0] virq_rd = HAS_EIC ?
        ({{(32-PRI_W){1'b0}}, gpri_q} << `CGTSR_PRI_LO) |
        ({28'h0, gess_q} << `CGTSR_ESS_LO) | {16'h0000, guest_vector_offset_q} :
        {14'h0, vip_q, 10'h000};

    // ****************************************
    // Guest shadow set map
    // ****************************************
    reg [3:0] lss_q;

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            lss_q <= 4'h0;
        else if (wr_ssmap && HAS_LSS)
            lss_q <= reg_wdata[`CGTSR_LSS_HI:0];
    end

    // ****************************************
    // Timer compare
    // ****************************************
    reg [31:0] cmp_q;

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            cmp_q <= 32'h0000_0000;
        else if (wr_cmp)
            cmp_q <= reg_wdata;
    end

    // ****************************************
    // Guest control extension
    // ****************************************
    reg [4:0] gext_q; // cgi, fcd, og, bg, mg
    wire [4:0] gext_wmask = {HAS_CGI, 1'b1, HAS_OG, HAS_BG, HAS_MG};

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            gext_q <= 5'h00;
        else if (wr_gext && HAS_GEXT)
            gext_q <= reg_wdata[4:0] & gext_wmask;
    end

    wire [31:0] gext_rd = HAS_GEXT ?
        {24'h0, `CGTSR_NCC_RST, 1'b0, gext_q} : 32'h0000_0000;

    // ****************************************
    // Status
    // ****************************************
    reg [31:0] stat_q;
    wire [31:0] stat_wmask = bitset(`CGTSR_CU2_BIT) & {32{HAS_COP2}} |
        bitset(`CGTSR_CU1_BIT) & {32{HAS_FPU}} |
        32'h1fff_ff17;

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            stat_q <= `CGTSR_STAT_RST;
        else if (wr_stat)
            stat_q <= reg_wdata & stat_wmask;
    end

    // ****************************************
    // Read mux
    // ****************************************
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata_q <= 32'h0000_0000;
        end else if (reg_rd) begin
            case (reg_sel)
                `CGTSR_SEL_VIRQ:  reg_rdata_q <= virq_rd;
                `CGTSR_SEL_SSMAP: reg_rdata_q <= {28'h0, lss_q};
                `CGTSR_SEL_CMP:   reg_rdata_q <= cmp_q;
                `CGTSR_SEL_GEXT:  reg_rdata_q <= gext_rd;
                `CGTSR_SEL_STAT:  reg_rdata_q <= stat_q;
                default:          reg_rdata_q <= 32'h0000_0000;
            endcase
        end
    end

    // ****************************************
    // Derived state and outputs
    // ****************************************
    wire ie  = stat_q[`CGTSR_IE_BIT];
    wire exception_level = stat_q[`CGTSR_EXL_BIT];
    wire error_level = stat_q[`CGTSR_ERL_BIT];
    wire um  = stat_q[`CGTSR_UM_BIT];
    wire irq_en = ie && !exception_level && !error_level && !debug_mode_flag;
    wire [3:0] cu = {stat_q[`CGTSR_CU3_BIT:`CGTSR_CU1_BIT], 1'b1};
    // Group bits map to the three register groups: misc, bad-addr, mmu
    wire [2:0] grp_trap = guest_reg_group_acc &
        (gext_q[2:0] | {3{!guest_cp0_access_en}});
    wire cgi_ok = gext_q[`CGTSR_CGI_BIT] && guest_cache_ctl_en;
    wire [5:0] timer_vec;

    // Pending bit n+2 maps to index n; route code 2..7 selects it
    assign timer_vec = {5'h00, timer_irq_out} <<
        (timer_irq_route - 3'h2);

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            timer_irq_out         <= 1'b0;
            guest_pending_q       <= 6'h00;
            guest_vector_q        <= 16'h0000;
            guest_ss_lo_q         <= 4'h0;
            guest_ss_hi_q         <= 4'h0;
            irq_enabled_q         <= 1'b0;
            irq_selected_q        <= 8'h00;
            user_mode_q           <= 1'b0;
            guest_privileged_trap <= 1'b0;
            field_change_exc_q    <= 1'b0;
            cop_unusable_exc_q    <= 1'b0;
        end else begin
            // Match sets, write clears; set wins on collision
            if (count_value == cmp_q)
                timer_irq_out <= 1'b1;
            else if (wr_cmp)
                timer_irq_out <= 1'b0;
            guest_pending_q <= vip_q[5:0] | ext_irq |
                ((timer_irq_route >= 3'h2) ? timer_vec : 6'h00);
            guest_vector_q <= (taken_in_root && HAS_EIC) ?
                guest_vector_offset_q : guest_bus_vector;
            guest_ss_lo_q <= lss_q;
            guest_ss_hi_q <= lss_q + highest_shadow_set;
            irq_enabled_q <= irq_en;
            irq_selected_q <= irq_en ? irq_request : 8'h00;
            user_mode_q <= !debug_mode_flag && um && !exception_level && !error_level;
            guest_privileged_trap <= (|grp_trap) ||
                (cache_idx_inv_guest && !cgi_ok);
            field_change_exc_q <= field_change_event &&
                !gext_q[`CGTSR_FCD_BIT];
            cop_unusable_exc_q <= |(cop_access & ~cu);
        end
    end

endmodule

/* design/cgtsr_regs.vh */
// Purpose: Constants for the guest, timer and status register slice
// Assumes: Register and select numbers form a 5+3 bit select code
// Notes:   Field positions are bit indices within a 32-bit word
`ifndef CGTSR_REGS_VH
`define CGTSR_REGS_VH

// ****************************************
// Register select codes {reg[4:0],sel[2:0]}
// ****************************************
`define CGTSR_SEL_VIRQ      8'h55
`define CGTSR_SEL_SSMAP     8'h56
`define CGTSR_SEL_CMP       8'h58
`define CGTSR_SEL_GEXT      8'h5c
`define CGTSR_SEL_STAT      8'h60

// ****************************************
// Field positions
// ****************************************
`define CGTSR_VIP_LO        10
`define CGTSR_VIP_HI        17
`define CGTSR_PRI_LO        24
`define CGTSR_ESS_LO        18
`define CGTSR_ESS_HI        21
`define CGTSR_VEC_HI        15
`define CGTSR_LSS_HI        3
`define CGTSR_NCC_LO        6
`define CGTSR_NCC_HI        7
`define CGTSR_CGI_BIT       4
`define CGTSR_FCD_BIT       3
`define CGTSR_OG_BIT        2
`define CGTSR_BG_BIT        1
`define CGTSR_MG_BIT        0
`define CGTSR_CU3_BIT       31
`define CGTSR_CU2_BIT       30
`define CGTSR_CU1_BIT       29
`define CGTSR_UM_BIT        4
`define CGTSR_ERL_BIT       2
`define CGTSR_EXL_BIT       1
`define CGTSR_IE_BIT        0

// ****************************************
// Reset values
// ****************************************
`define CGTSR_NCC_RST       2'h1
`define CGTSR_STAT_RST      32'h0000_0004

`endif
